// ### rtl/lisc_regs.vh
// register offsets, field positions and reset values for legacy index and system control
`ifndef LISC_REGS_VH
`define LISC_REGS_VH
`define LISC_OFF_LEGACY_BASE   8'h44
`define LISC_OFF_SYS_CTRL      8'h80
`define LISC_LEGACY_RESET      32'h00000001
`define LISC_SYS_CTRL_RESET    32'h00449060
`define LISC_BIT_STEP_HI       31
`define LISC_BIT_STEP_LO       30
`define LISC_BIT_TIE           29
`define LISC_BIT_RSVD28        28
`define LISC_BIT_CLK_SRC       27
`define LISC_BIT_ROUTE         26
`define LISC_BIT_SMI_FLAG      25
`define LISC_BIT_SMI_EN        24
`define LISC_OSC_DIV           8'h04
`endif

// ### rtl/lisc_clk_sel.v
// power-switch clock source selection and internal oscillator divider
`timescale 1ns/1ps
module lisc_clk_sel #(
    parameter DIV = 4
) (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_src_internal,
    input  wire       i_ext_clk,
    output reg        o_clk_out,
    output reg        o_clk_oe,
    output reg        o_sel_clk
);
    reg  [7:0] cnt_q;
    reg        osc_q;
    always @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q     <= 8'h00;
            osc_q     <= 1'b0;
            o_clk_out <= 1'b0;
            o_clk_oe  <= 1'b0;
            o_sel_clk <= 1'b0;
        end else begin
            if (cnt_q == DIV[7:0] - 8'h01) begin
                cnt_q <= 8'h00;
                osc_q <= ~osc_q;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
            o_clk_oe  <= i_src_internal;
            o_clk_out <= osc_q;
            o_sel_clk <= i_src_internal ? osc_q : i_ext_clk;
        end
    end
endmodule // lisc_clk_sel

// ### rtl/lisc_irq_step.v
// maps first and second internal interrupts onto serialized slots a..d
`timescale 1ns/1ps
module lisc_irq_step (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire [1:0] i_step,
    input  wire       i_tie,
    input  wire       i_irq_a,
    input  wire       i_irq_b,
    output reg  [3:0] o_slots
);
    wire       a_eff;
    wire       b_eff;
    reg  [3:0] slots_d;
    assign a_eff = i_tie ? (i_irq_a | i_irq_b) : i_irq_a;
    assign b_eff = i_tie ? 1'b0 : i_irq_b;
    always @* begin
        case (i_step)
            2'h0:    slots_d = {2'h0, b_eff, a_eff};
            2'h1:    slots_d = {1'b0, b_eff, a_eff, 1'b0};
            default: slots_d = {b_eff, a_eff, 2'h0};
        endcase
    end
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_slots <= 4'h0;
        end else begin
            o_slots <= slots_d;
        end
    end
endmodule // lisc_irq_step

// ### rtl/lisc_top.v
// legacy index/data base register and upper system control bits
// Operation
// - io access at base is index port, base plus one is data port
// - base bit 0 reads one; bits 31..1 read/write, reset zero
// - one base register shared by both configuration functions
// - step field places interrupts in slots a/b, b/c, c/d, c/d
// - tie bit merges second interrupt into first, still stepped
// - clock source 0 takes external input, 1 drives internal oscillator out
// - selected clock drives the serial power switch clock output
// - socket power write raises irq2 when route 0, status change when 1
// - smi enable plus socket power write signals smi interrupt
// - per-socket smi flag set by power write when enabled, write one clears
// - global bits writable only through function 0, except route, which either function writes
// - bit 28 of system control reads zero
`timescale 1ns/1ps
`include "lisc_regs.vh"
module lisc_top #(
    parameter OSC_DIV = 4,
    parameter COMPAT_DEPTH = 64
) (
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_cfg_wr,
    input  wire        i_cfg_rd,
    input  wire        i_cfg_func,
    input  wire [7:0]  i_cfg_addr,
    input  wire [3:0]  i_cfg_be,
    input  wire [31:0] i_cfg_wdata,
    output reg  [31:0] o_cfg_rdata,
    input  wire        i_io_wr,
    input  wire        i_io_rd,
    input  wire [31:0] i_io_addr,
    input  wire [7:0]  i_io_wdata,
    output reg  [7:0]  o_io_rdata,
    output reg         o_io_hit,
    input  wire        i_sock_pwr_wr,
    input  wire        i_sock_sel,
    input  wire        i_irq_a,
    input  wire        i_irq_b,
    output reg  [3:0]  o_irq_slots,
    output reg         o_irq2,
    output reg         o_card_status_change_irq,
    output reg         o_smi,
    input  wire        i_ext_clk,
    output reg         o_clk_out,
    output reg         o_clk_oe,
    output reg         o_pwr_sw_clk
);
    reg  [31:1] base_q;
    reg  [1:0]  step_q;
    reg         tie_q;
    reg         clk_src_q;
    reg         route_q;
    reg         smi_en_q;
    reg  [1:0]  smi_flag_q;
    reg  [7:0]  index_q;
    reg  [7:0]  compat_q [0:COMPAT_DEPTH-1];
    wire [3:0]  slots_w;
    wire        clk_out_w;
    wire        clk_oe_w;
    wire        sel_clk_w;
    wire        idx_hit;
    wire        dat_hit;
    wire        g_wr;
    wire        sc_wr;
    wire        pwr_smi;
    wire [31:0] sys_rd;
    wire [31:0] base_addr;
    wire [31:0] base_new;
    wire [5:0]  cidx;
    integer     k;

    function [31:0] be_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer j;
        begin
            be_merge = old_v;
            for (j = 0; j < 4; j = j + 1) begin
                if (be[j]) begin
                    be_merge[j*8 +: 8] = new_v[j*8 +: 8];
                end
            end
        end
    endfunction

    // bit 0 of the register only marks io space; the port pair sits on an even address
    assign base_addr = {base_q, 1'b0};
    assign idx_hit   = (i_io_addr == base_addr);
    assign dat_hit   = (i_io_addr == {base_q, 1'b1});
    assign base_new  = be_merge({base_q, 1'b1}, i_cfg_wdata, i_cfg_be);
    assign cidx    = index_q[5:0];
    assign sc_wr   = i_cfg_wr && (i_cfg_addr == `LISC_OFF_SYS_CTRL) && i_cfg_be[3];
    assign g_wr    = sc_wr && !i_cfg_func;
    assign pwr_smi = i_sock_pwr_wr && smi_en_q;
    assign sys_rd  = {step_q, tie_q, 1'b0, clk_src_q, route_q,
                      smi_flag_q[i_cfg_func], smi_en_q, 24'h449060};

    lisc_irq_step u_step (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_step  (step_q),
        .i_tie   (tie_q),
        .i_irq_a (i_irq_a),
        .i_irq_b (i_irq_b),
        .o_slots (slots_w)
    );

    lisc_clk_sel #(.DIV(OSC_DIV)) u_clk (
        .i_clk          (i_clk),
        .i_srst         (i_srst),
        .i_src_internal (clk_src_q),
        .i_ext_clk      (i_ext_clk),
        .o_clk_out      (clk_out_w),
        .o_clk_oe       (clk_oe_w),
        .o_sel_clk      (sel_clk_w)
    );

    always @(posedge i_clk) begin
        if (i_srst) begin
            base_q     <= 31'h00000000;
            step_q     <= 2'h0;
            tie_q      <= 1'b0;
            clk_src_q  <= 1'b0;
            route_q    <= 1'b0;
            smi_en_q   <= 1'b0;
            smi_flag_q <= 2'h0;
            index_q    <= 8'h00;
            for (k = 0; k < COMPAT_DEPTH; k = k + 1) begin
                compat_q[k] <= 8'h00;
            end
        end else begin
            if (i_cfg_wr && (i_cfg_addr == `LISC_OFF_LEGACY_BASE)) begin
                base_q <= base_new[31:1];
            end
            if (g_wr) begin
                step_q    <= i_cfg_wdata[`LISC_BIT_STEP_HI:`LISC_BIT_STEP_LO];
                tie_q     <= i_cfg_wdata[`LISC_BIT_TIE];
                clk_src_q <= i_cfg_wdata[`LISC_BIT_CLK_SRC];
                smi_en_q  <= i_cfg_wdata[`LISC_BIT_SMI_EN];
            end
            if (sc_wr) begin
                route_q <= i_cfg_wdata[`LISC_BIT_ROUTE];
            end
            for (k = 0; k < 2; k = k + 1) begin
                if (pwr_smi && (i_sock_sel == k[0])) begin
                    smi_flag_q[k] <= 1'b1;
                end else if (sc_wr && (i_cfg_func == k[0])
                             && i_cfg_wdata[`LISC_BIT_SMI_FLAG]) begin
                    smi_flag_q[k] <= 1'b0;
                end
            end
            if (i_io_wr && idx_hit) begin
                index_q <= i_io_wdata;
            end
            if (i_io_wr && dat_hit && (index_q < COMPAT_DEPTH)) begin
                compat_q[cidx] <= i_io_wdata;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            o_cfg_rdata              <= 32'h00000000;
            o_io_rdata               <= 8'h00;
            o_io_hit                 <= 1'b0;
            o_irq_slots              <= 4'h0;
            o_irq2                   <= 1'b0;
            o_card_status_change_irq <= 1'b0;
            o_smi                    <= 1'b0;
            o_clk_out                <= 1'b0;
            o_clk_oe                 <= 1'b0;
            o_pwr_sw_clk             <= 1'b0;
        end else begin
            if (i_cfg_rd) begin
                case (i_cfg_addr)
                    `LISC_OFF_LEGACY_BASE: o_cfg_rdata <= {base_q, 1'b1};
                    `LISC_OFF_SYS_CTRL:    o_cfg_rdata <= sys_rd;
                    default:               o_cfg_rdata <= 32'h00000000;
                endcase
            end
            o_io_hit <= (i_io_wr || i_io_rd) && (idx_hit || dat_hit);
            if (i_io_rd && idx_hit) begin
                o_io_rdata <= index_q;
            end else if (i_io_rd && dat_hit) begin
                o_io_rdata <= (index_q < COMPAT_DEPTH) ? compat_q[cidx] : 8'h00;
            end
            o_irq_slots              <= slots_w;
            o_irq2                   <= i_sock_pwr_wr && !route_q;
            o_card_status_change_irq <= i_sock_pwr_wr && route_q;
            o_smi                    <= pwr_smi;
            o_clk_out                <= clk_out_w;
            o_clk_oe                 <= clk_oe_w;
            o_pwr_sw_clk             <= sel_clk_w;
        end
    end
endmodule // lisc_top

// ### verif/lisc_properties.sv
// port assertions for legacy index and system control
`timescale 1ns/1ps
module lisc_properties (
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic        i_cfg_rd,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        i_io_wr,
    input wire logic        i_io_rd,
    input wire logic        o_io_hit,
    input wire logic        i_sock_pwr_wr,
    input wire logic        i_irq_a,
    input wire logic        i_irq_b,
    input wire logic [3:0]  o_irq_slots,
    input wire logic        o_irq2,
    input wire logic        o_card_status_change_irq,
    input wire logic        o_smi,
    input wire logic        i_ext_clk,
    input wire logic        o_clk_oe,
    input wire logic        o_pwr_sw_clk
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_base_bit_one: assert property (i_cfg_rd && i_cfg_addr == 8'h44 |=> o_cfg_rdata[0])
        else $error("base bit 0 not one");
    a_rsvd_bit_zero: assert property (i_cfg_rd && i_cfg_addr == 8'h80 |=> !o_cfg_rdata[28])
        else $error("bit 28 not zero");
    a_io_hit_cause: assert property (o_io_hit |-> $past(i_io_wr | i_io_rd))
        else $error("io hit without access");
    a_route_one_hot: assert property (i_sock_pwr_wr |=> o_irq2 != o_card_status_change_irq)
        else $error("power write routing wrong");
    a_no_spurious_irq: assert property (!i_sock_pwr_wr |=> !o_irq2 && !o_card_status_change_irq)
        else $error("irq without power write");
    a_smi_has_cause: assert property (o_smi |-> $past(i_sock_pwr_wr))
        else $error("smi without power write");
    a_slots_idle: assert property ($past(i_irq_a | i_irq_b, 2) == 1'b0 |-> o_irq_slots == 4'h0)
        else $error("slot active without irq");
    a_slot_a_cause: assert property (o_irq_slots[0] |-> $past(i_irq_a | i_irq_b, 2))
        else $error("slot a without cause");
    a_slot_d_cause: assert property (o_irq_slots[3] |-> $past(i_irq_b, 2))
        else $error("slot d without second irq");
    a_ext_clk_follow: assert property (!o_clk_oe && $past(!o_clk_oe, 2) && !$past(i_srst, 2)
        |-> o_pwr_sw_clk == $past(i_ext_clk, 2))
        else $error("switch clock not external");
endmodule // lisc_properties
bind lisc_top lisc_properties u_props (.i_clk, .i_srst, .i_cfg_rd, .i_cfg_addr, .o_cfg_rdata,
    .i_io_wr, .i_io_rd, .o_io_hit, .i_sock_pwr_wr, .i_irq_a, .i_irq_b, .o_irq_slots, .o_irq2,
    .o_card_status_change_irq, .o_smi, .i_ext_clk, .o_clk_oe, .o_pwr_sw_clk);

// ### verif/testbench.sv
// self-checking bench for legacy index and system control
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic        wf;
        logic [7:0]  ad;
        logic [31:0] wd;
        logic        rf;
        logic [31:0] ex;
        logic [1:0]  irq;
        logic [3:0]  sl;
    } lisc_row_t;
    logic        i_clk = 0, i_srst = 1, i_cfg_wr = 0, i_cfg_rd = 0, i_cfg_func = 0, pc;
    logic [7:0]  i_cfg_addr = 8'h00, i_io_wdata = 8'h00, o_io_rdata;
    logic [3:0]  i_cfg_be = 4'h0, o_irq_slots;
    logic [31:0] i_cfg_wdata = 32'h0, i_io_addr = 32'h0, o_cfg_rdata;
    logic        i_io_wr = 0, i_io_rd = 0, i_sock_pwr_wr = 0, i_sock_sel = 0, i_irq_a = 0;
    logic        i_irq_b = 0, i_ext_clk = 0, o_io_hit, o_irq2, o_card_status_change_irq;
    logic        o_smi, o_clk_out, o_clk_oe, o_pwr_sw_clk, po;
    int          err_count = 0, compares = 0, n, m;
    lisc_row_t   rows [0:11];
    lisc_top #(.OSC_DIV(4), .COMPAT_DEPTH(64)) dut (.i_clk, .i_srst, .i_cfg_wr, .i_cfg_rd,
        .i_cfg_func, .i_cfg_addr, .i_cfg_be, .i_cfg_wdata, .o_cfg_rdata, .i_io_wr, .i_io_rd,
        .i_io_addr, .i_io_wdata, .o_io_rdata, .o_io_hit, .i_sock_pwr_wr, .i_sock_sel, .i_irq_a,
        .i_irq_b, .o_irq_slots, .o_irq2, .o_card_status_change_irq, .o_smi, .i_ext_clk,
        .o_clk_out, .o_clk_oe, .o_pwr_sw_clk);
    always #12.5 i_clk = ~i_clk;
    always @(negedge i_clk) i_ext_clk <= ~i_ext_clk;
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task cfg(input logic w, input logic f, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
        @(negedge i_clk);
        {i_cfg_wr, i_cfg_rd, i_cfg_func, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {w, !w, f, a, b, d};
        @(negedge i_clk);
        {i_cfg_wr, i_cfg_rd} = 2'b00;
    endtask
    task io(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {i_io_wr, i_io_rd, i_io_addr, i_io_wdata} = {w, !w, a, d};
        @(negedge i_clk);
        {i_io_wr, i_io_rd} = 2'b00;
    endtask
    task pwr();
        @(negedge i_clk);
        i_sock_pwr_wr = 1'b1;
        @(negedge i_clk);
        i_sock_pwr_wr = 1'b0;
    endtask
    task print_verdict();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        rows = '{'{1'b0, 8'h44, 32'h00000300, 1'b1, 32'h00000301, 2'b00, 4'h0},
            '{1'b1, 8'h44, 32'hFFFFFFFE, 1'b0, 32'hFFFFFFFF, 2'b00, 4'h0},
            '{1'b0, 8'h44, 32'h00000300, 1'b0, 32'h00000301, 2'b00, 4'h0},
            '{1'b0, 8'h48, 32'hFFFFFFFF, 1'b0, 32'h00000000, 2'b00, 4'h0},
            '{1'b1, 8'h80, 32'hFF000000, 1'b1, 32'h04449060, 2'b11, 4'h3},
            '{1'b0, 8'h80, 32'h00000000, 1'b0, 32'h00449060, 2'b11, 4'h3},
            '{1'b0, 8'h80, 32'h40000000, 1'b0, 32'h40449060, 2'b11, 4'h6},
            '{1'b0, 8'h80, 32'h80000000, 1'b0, 32'h80449060, 2'b11, 4'hC},
            '{1'b0, 8'h80, 32'hC0000000, 1'b0, 32'hC0449060, 2'b11, 4'hC},
            '{1'b0, 8'h80, 32'h20000000, 1'b0, 32'h20449060, 2'b01, 4'h1},
            '{1'b0, 8'h80, 32'hA0000000, 1'b0, 32'hA0449060, 2'b01, 4'h4},
            '{1'b1, 8'h80, 32'hFF000000, 1'b0, 32'hA4449060, 2'b10, 4'h4}};
        repeat (20) @(negedge i_clk);
        i_srst = 0;
        for (n = 0; n < 12; n++) begin
            cfg(1'b1, rows[n].wf, rows[n].ad, 4'hF, rows[n].wd);
            {i_irq_a, i_irq_b} = rows[n].irq;
            cfg(1'b0, rows[n].rf, rows[n].ad, 4'hF, 32'h0);
            chk(o_cfg_rdata === rows[n].ex, "cfg readback");
            repeat (2) @(negedge i_clk);
            chk(o_irq_slots === rows[n].sl, "irq slots");
        end
        cfg(1'b1, 1'b0, 8'h80, 4'h7, 32'hFF000000);
        cfg(1'b0, 1'b0, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'hA4449060, "upper byte off");
        io(1'b1, 32'h300, 8'h05);
        io(1'b1, 32'h301, 8'hAA);
        io(1'b0, 32'h301, 8'h00);
        chk(o_io_rdata === 8'hAA && o_io_hit === 1'b1, "data port");
        io(1'b0, 32'h300, 8'h00);
        chk(o_io_rdata === 8'h05, "index port");
        io(1'b0, 32'h302, 8'h00);
        chk(o_io_hit === 1'b0, "io miss");
        pwr();
        chk(o_card_status_change_irq === 1'b1 && o_irq2 === 1'b0 && o_smi === 1'b0, "route");
        cfg(1'b1, 1'b0, 8'h80, 4'h8, 32'hA1000000);
        pwr();
        chk(o_irq2 === 1'b1 && o_smi === 1'b1, "smi");
        cfg(1'b0, 1'b0, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'hA3449060, "smi flag set");
        cfg(1'b1, 1'b0, 8'h80, 4'h8, 32'hA3000000);
        cfg(1'b0, 1'b0, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'hA1449060, "smi flag clear");
        chk(o_clk_oe === 1'b0, "external clock");
        cfg(1'b1, 1'b0, 8'h80, 4'h8, 32'hA9000000);
        n = 0;
        m = 0;
        repeat (40) begin
            pc = o_pwr_sw_clk;
            po = o_clk_out;
            @(negedge i_clk);
            if (o_pwr_sw_clk !== pc) n++;
            if (o_clk_out !== po) m++;
        end
        chk(o_clk_oe === 1'b1 && n >= 4 && n <= 12, "internal clock");
        chk(m >= 8 && m <= 11, "oscillator out");
        i_sock_sel = 1'b1;
        pwr();
        cfg(1'b0, 1'b1, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'hAB449060, "socket one flag");
        cfg(1'b0, 1'b0, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'hA9449060, "socket zero flag");
        cfg(1'b1, 1'b1, 8'h80, 4'h8, 32'h02000000);
        cfg(1'b0, 1'b1, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'hA9449060, "socket one clear");
        i_srst = 1;
        repeat (2) @(negedge i_clk);
        chk(o_clk_oe === 1'b0 && o_clk_out === 1'b0 && o_pwr_sw_clk === 1'b0
            && o_irq_slots === 4'h0 && o_io_hit === 1'b0, "reset outputs");
        i_srst = 0;
        cfg(1'b0, 1'b1, 8'h44, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'h00000001, "base reset");
        cfg(1'b0, 1'b0, 8'h80, 4'hF, 32'h0);
        chk(o_cfg_rdata === 32'h00449060, "sysctl reset");
        print_verdict();
    end
endmodule // testbench
